//--- shared/lgp_pkg.sv
// Purpose: constants for the link pin configuration block
// Assumes: apb byte addressing, 32-bit data
// Notes:   printed offsets not all multiples of four, so they are indices
package lgp_pkg;
  localparam logic [7:0]  IDX_PINS_ONE_TWO  = 8'h0e;
  localparam logic [7:0]  IDX_PIN_THREE     = 8'h0f;
  localparam logic [7:0]  IDX_PINS_FIVE_SIX = 8'h10;
  localparam logic [7:0]  IDX_PORT_CTRL     = 8'h20;
  localparam logic [7:0]  IDX_PIN_STATUS    = 8'h21;
  localparam int          ADDR_W            = 12;
  localparam logic [7:0]  CFG_RESET         = 8'h00;
  localparam logic [7:0]  MASK_ONE_TWO      = 8'hff;
  localparam logic [7:0]  MASK_THREE        = 8'h0f;
  localparam logic [7:0]  MASK_FIVE_SIX     = 8'hbb;
  localparam int          HI_VAL_BIT        = 7;
  localparam int          HI_MODE_LSB       = 4;
  localparam int          LO_VAL_BIT        = 3;
  localparam int          LO_MODE_LSB       = 0;
  localparam int          SEL_BIT           = 0;
  localparam logic [2:0]  MODE_OUT          = 3'h1;
  localparam logic [2:0]  MODE_IN           = 3'h3;
  localparam logic [2:0]  MODE_REM_HOLD     = 3'h5;
  localparam logic [2:0]  MODE_REM_DEF      = 3'h7;
  localparam logic [1:0]  MODE_FUNC_LO      = 2'h0;
  localparam logic [1:0]  MODE_TRI_LO       = 2'h2;
  localparam logic [1:0]  MODE2_OUT         = 2'h1;
  localparam logic [1:0]  MODE2_IN          = 2'h3;
  typedef enum logic [1:0] {
    LGP_FUNC,
    LGP_TRI,
    LGP_OUT,
    LGP_IN
  } lgp_dir_t;
endpackage : lgp_pkg

//--- verification/lgp_far_side.sv
// Purpose: board pads and remote receiver facing the pin block
// Assumes: bench commands link state, remote values and board levels
// Notes:   a pad the block drives reads back its own drive value
`timescale 1ns/10ps
`default_nettype none
module lgp_far_side (
  input  wire logic       pclk,       // register clock
  input  wire logic [1:0] link_req,   // wanted link state per port
  input  wire logic [5:0] rem_req,    // wanted remote pin values
  input  wire logic [7:0] ext_lvl,    // board level on undriven pads
  input  wire logic [7:0] drv_val,    // block drive value
  input  wire logic [7:0] drv_en,     // block drive enable
  output logic      [1:0] link_up,    // link status per port
  output logic      [5:0] remote_val, // remote pin values
  output logic      [7:0] pad_lvl     // resolved pad levels
);
  // receiver updates just after an edge, never mid-cycle
  always_ff @(posedge pclk)
  begin
    link_up    <= link_req;
    remote_val <= rem_req;
  end
  assign pad_lvl = (drv_en & drv_val) | (~drv_en & ext_lvl);
endmodule : lgp_far_side
`default_nettype wire

//--- verification/lgp_pin_config_bench.sv
// Purpose: self-checking bench for the pin configuration block
// Assumes: far side model supplies pads and remote values
// Notes:   register byte address is four times the index
`timescale 1ns/10ps
`default_nettype none
module lgp_pin_config_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  link_up, link_req, pin56_out, pin56_oe, pin56_func;
  logic [5:0]  remote_val, rem_req, pin_out, pin_oe, pin_func;
  logic [7:0]  ext_lvl, pad_lvl;
  int          error_cnt = 0;
  int          comparisons = 0;

  lgp_pin_config #(.NPORT(2)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link_up(link_up),
    .remote_val(remote_val), .pin_in(pad_lvl[5:0]),
    .pin56_in(pad_lvl[7:6]), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_func(pin_func), .pin56_out(pin56_out), .pin56_oe(pin56_oe),
    .pin56_func(pin56_func));
  lgp_far_side i_far (
    .pclk(pclk), .link_req(link_req), .rem_req(rem_req),
    .ext_lvl(ext_lvl), .drv_val({pin56_out, pin_out}),
    .drv_en({pin56_oe, pin_oe}), .link_up(link_up),
    .remote_val(remote_val), .pad_lvl(pad_lvl));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 16)
      error_cnt++;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] idx, exp);
    apb(1'b0, idx, 32'h0);
    chk(nm, rd, {24'h0, exp});
  endtask : rdc

  // pin outputs follow the register one cycle late
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  function automatic logic [2:0] see(input int i);
    return {pin_func[i], pin_oe[i], pin_oe[i] & pin_out[i]};
  endfunction : see

  function automatic logic [2:0] exp_pin(input logic [2:0] m,
                                         input logic v, r);
    logic oe;
    oe = m[0] && m != 3'h3;
    return {m[1:0] == 2'h0, oe, oe & (m == 3'h1 ? v : r)};
  endfunction : exp_pin

  task automatic t_reset;
    rdc("one_two", lgp_pkg::IDX_PINS_ONE_TWO, 8'h00);
    rdc("three", lgp_pkg::IDX_PIN_THREE, 8'h00);
    rdc("five_six", lgp_pkg::IDX_PINS_FIVE_SIX, 8'h00);
    chk("rst_out", {pin56_out, pin_out, pin56_oe, pin_oe}, 0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_modes;
    logic [2:0] m;
    rem_req <= 6'h01;
    for (int i = 0; i < 8; i++)
    begin
      m = 3'(i);
      apb(1'b1, lgp_pkg::IDX_PINS_ONE_TWO, {24'h0, 1'b1, m, 1'b0, m});
      apb(1'b1, lgp_pkg::IDX_PIN_THREE, {28'h0, 1'b1, m});
      settle();
      chk("pin_one", see(0), exp_pin(m, 1'b0, 1'b1));
      chk("pin_two", see(1), exp_pin(m, 1'b1, 1'b0));
      chk("pin_three", see(2), exp_pin(m, 1'b1, 1'b0));
      rdc("one_two_rd", lgp_pkg::IDX_PINS_ONE_TWO, {1'b1, m, 1'b0, m});
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_loss;
    // remote and local values differ so each fallback is told apart
    rem_req <= 6'h01;
    apb(1'b1, lgp_pkg::IDX_PINS_ONE_TWO, 32'hf5);
    apb(1'b1, lgp_pkg::IDX_PIN_THREE, 32'h0f);
    settle();
    chk("hold_up", see(0), 3'h3);
    chk("dflt_up", see(1), 3'h2);
    chk("dflt3_up", see(2), 3'h2);
    link_req <= 2'b10;
    rem_req  <= 6'h00;
    settle();
    chk("hold_lost", see(0), 3'h3);
    chk("dflt_lost", see(1), 3'h3);
    chk("dflt3_lost", see(2), 3'h3);
    link_req <= 2'b11;
    $display("test link loss done");
  endtask : t_loss

  task automatic t_sel;
    apb(1'b1, lgp_pkg::IDX_PINS_ONE_TWO, 32'h0);
    apb(1'b1, lgp_pkg::IDX_PIN_THREE, 32'h0);
    apb(1'b1, lgp_pkg::IDX_PORT_CTRL, 32'h1);
    apb(1'b1, lgp_pkg::IDX_PINS_ONE_TWO, 32'h99);
    apb(1'b1, lgp_pkg::IDX_PIN_THREE, 32'h09);
    settle();
    chk("sec_pins", {pin_oe[5:3], pin_out[5:3]}, 6'h3f);
    chk("pri_pins", {pin_oe[2:0], pin_func[2:0]}, 6'h07);
    rdc("sec_rd", lgp_pkg::IDX_PINS_ONE_TWO, 8'h99);
    apb(1'b1, lgp_pkg::IDX_PORT_CTRL, 32'h0);
    rdc("pri_rd", lgp_pkg::IDX_PINS_ONE_TWO, 8'h00);
    $display("test port select done");
  endtask : t_sel

  task automatic t_regs;
    apb(1'b1, lgp_pkg::IDX_PIN_THREE, 32'hffffffff);
    rdc("three_rsv", lgp_pkg::IDX_PIN_THREE, 8'h0f);
    apb(1'b1, lgp_pkg::IDX_PINS_FIVE_SIX, 32'hffffffff);
    rdc("five_six_rsv", lgp_pkg::IDX_PINS_FIVE_SIX, 8'hbb);
    apb(1'b1, 8'h30, 32'hffffffff);
    chk("unmapped_wr_err", err, 1'b1);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped_err", err, 1'b1);
    chk("unmapped_rd", rd, 32'h0);
    settle();
    rdc("status", lgp_pkg::IDX_PIN_STATUS, pad_lvl);
    $display("test registers done");
  endtask : t_regs

  task automatic t_pin56;
    logic [7:0] w[5] = '{8'h99, 8'h19, 8'hbb, 8'haa, 8'h00};
    logic [5:0] e[5] = '{6'h0f, 6'h0d, 6'h00, 6'h00, 6'h30};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, lgp_pkg::IDX_PINS_FIVE_SIX, {24'h0, w[i]});
      settle();
      chk("pin56", {pin56_func, pin56_oe, pin56_oe & pin56_out}, e[i]);
    end
    $display("test pins five six done");
  endtask : t_pin56

  initial
  begin
    presetn  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h0;
    link_req = 2'b11;
    rem_req  = 6'h00;
    ext_lvl  = 8'h5a;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_loss();
    t_sel();
    t_regs();
    t_pin56();
    finish_test();
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    finish_test();
  end
endmodule : lgp_pin_config_bench
`default_nettype wire

//--- verilog/lgp_pin_config.sv
// Purpose: apb register block configuring link serializer pins
// Assumes: single clock, pin inputs synchronous to pclk
// Notes:   pins 1..3 on primary and secondary port, pins 5 and 6 primary
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lgp_pin_config #(
  parameter int NPORT = 2
) (
  input  wire logic              pclk,         // register clock
  input  wire logic              presetn,      // async reset, low
  input  wire logic              psel,         // apb select
  input  wire logic              penable,      // apb access phase
  input  wire logic              pwrite,       // apb direction
  input  wire logic [11:0]       paddr,        // apb byte address
  input  wire logic [31:0]       pwdata,       // apb write data
  output logic      [31:0]       prdata,       // apb read data
  output logic                   pready,       // apb ready
  output logic                   pslverr,      // apb error
  input  wire logic [NPORT-1:0]  link_up,      // link status per port
  input  wire logic [NPORT*3-1:0] remote_val,  // remote pins 1..3 per port
  input  wire logic [NPORT*3-1:0] pin_in,      // pad levels pins 1..3
  input  wire logic [1:0]        pin56_in,     // pad levels pins 5,6
  output logic [NPORT*3-1:0]     pin_out,      // pad drive value
  output logic [NPORT*3-1:0]     pin_oe,       // pad drive enable
  output logic [NPORT*3-1:0]     pin_func,     // functional input select
  output logic [1:0]             pin56_out,    // pins 5,6 drive value
  output logic [1:0]             pin56_oe,     // pins 5,6 drive enable
  output logic [1:0]             pin56_func    // pins 5,6 functional
);

  // elaboration check: the port map below is written for two ports
  if (NPORT != 2)
  begin : g_bad_nport
    $error("lgp_pin_config serves exactly two ports");
  end

  logic [7:0]           one_two_r [NPORT];
  logic [7:0]           three_r   [NPORT];
  logic [7:0]           five_six_r;
  logic                 port_sel_r;
  logic [NPORT*3-1:0]   held_r;
  logic [NPORT*3-1:0]   pin_in_r;
  logic [1:0]           pin56_in_r;
  logic [31:0]          prdata_nxt;
  logic                 unmapped;
  logic                 wr_acc;
  logic                 rd_setup;
  logic [7:0]           idx;

  // word index from the byte address; low bits must be zero
  assign idx      = paddr[9:2];
  assign wr_acc   = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable && !pwrite;

  function automatic logic is_mapped(input logic [11:0] a);
    logic [7:0] i;
    i = a[9:2];
    is_mapped = (a[1:0] == 2'h0) && (a[11:10] == 2'h0) &&
                (i == lgp_pkg::IDX_PINS_ONE_TWO ||
                 i == lgp_pkg::IDX_PIN_THREE ||
                 i == lgp_pkg::IDX_PINS_FIVE_SIX ||
                 i == lgp_pkg::IDX_PORT_CTRL ||
                 i == lgp_pkg::IDX_PIN_STATUS);
  endfunction : is_mapped

  // three-bit mode decode shared by pins one to three
  function automatic lgp_pkg::lgp_dir_t decode3(input logic [2:0] m);
    if (m[1:0] == lgp_pkg::MODE_FUNC_LO)
      decode3 = lgp_pkg::LGP_FUNC;
    else if (m[1:0] == lgp_pkg::MODE_TRI_LO)
      decode3 = lgp_pkg::LGP_TRI;
    else if (m == lgp_pkg::MODE_IN)
      decode3 = lgp_pkg::LGP_IN;
    else
      decode3 = lgp_pkg::LGP_OUT;
  endfunction : decode3

  function automatic lgp_pkg::lgp_dir_t decode2(input logic [1:0] m);
    unique case (m)
      lgp_pkg::MODE_FUNC_LO: decode2 = lgp_pkg::LGP_FUNC;
      lgp_pkg::MODE_TRI_LO:  decode2 = lgp_pkg::LGP_TRI;
      lgp_pkg::MODE2_OUT:    decode2 = lgp_pkg::LGP_OUT;
      lgp_pkg::MODE2_IN:     decode2 = lgp_pkg::LGP_IN;
    endcase
  endfunction : decode2

  // zero wait states: ready answers in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  assign unmapped = !is_mapped(paddr);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pslverr <= 1'b0;
    else
      pslverr <= psel && !penable && unmapped;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      port_sel_r <= 1'b0;
    else if (wr_acc && !unmapped && idx == lgp_pkg::IDX_PORT_CTRL)
      port_sel_r <= pwdata[lgp_pkg::SEL_BIT];
  end

  // per-port configuration, written through the port select
  for (genvar p = 0; p < NPORT; p++)
  begin : g_port
    logic hit;
    assign hit = (port_sel_r == 1'(p));
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        one_two_r[p] <= lgp_pkg::CFG_RESET;
        three_r[p]   <= lgp_pkg::CFG_RESET;
      end
      else if (wr_acc && !unmapped && hit)
      begin
        if (idx == lgp_pkg::IDX_PINS_ONE_TWO)
          one_two_r[p] <= pwdata[7:0] & lgp_pkg::MASK_ONE_TWO;
        if (idx == lgp_pkg::IDX_PIN_THREE)
          three_r[p] <= pwdata[7:0] & lgp_pkg::MASK_THREE;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      five_six_r <= lgp_pkg::CFG_RESET;
    else if (wr_acc && !unmapped && idx == lgp_pkg::IDX_PINS_FIVE_SIX)
      five_six_r <= pwdata[7:0] & lgp_pkg::MASK_FIVE_SIX;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_in_r   <= '0;
      pin56_in_r <= 2'h0;
    end
    else
    begin
      pin_in_r   <= pin_in;
      pin56_in_r <= pin56_in;
    end
  end

  always_comb
  begin
    prdata_nxt = 32'h0000_0000;
    unique case (idx)
      lgp_pkg::IDX_PINS_ONE_TWO:
        prdata_nxt[7:0] = one_two_r[port_sel_r];
      lgp_pkg::IDX_PIN_THREE:
        prdata_nxt[7:0] = three_r[port_sel_r];
      lgp_pkg::IDX_PINS_FIVE_SIX:
        prdata_nxt[7:0] = five_six_r;
      lgp_pkg::IDX_PORT_CTRL:
        prdata_nxt[lgp_pkg::SEL_BIT] = port_sel_r;
      lgp_pkg::IDX_PIN_STATUS:
        prdata_nxt[7:0] = {pin56_in_r, pin_in_r};
      default:
        prdata_nxt = 32'h0000_0000;
    endcase
    if (unmapped)
      prdata_nxt = 32'h0000_0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup)
      prdata <= prdata_nxt;
  end

  // remote value is latched only while the link is up, so a lost link holds
  for (genvar p = 0; p < NPORT; p++)
  begin : g_hold
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        held_r[p*3 +: 3] <= 3'h0;
      else if (link_up[p])
        held_r[p*3 +: 3] <= remote_val[p*3 +: 3];
    end
  end

  for (genvar k = 0; k < NPORT*3; k++)
  begin : g_pin
    localparam int P = k / 3;
    localparam int N = k % 3;
    logic [2:0]        mode;
    logic              lval;
    logic              rem;
    lgp_pkg::lgp_dir_t dir;
    always_comb
    begin
      unique case (N)
        0: mode = one_two_r[P][lgp_pkg::LO_MODE_LSB +: 3];
        1: mode = one_two_r[P][lgp_pkg::HI_MODE_LSB +: 3];
        default: mode = three_r[P][lgp_pkg::LO_MODE_LSB +: 3];
      endcase
      unique case (N)
        0: lval = one_two_r[P][lgp_pkg::LO_VAL_BIT];
        1: lval = one_two_r[P][lgp_pkg::HI_VAL_BIT];
        default: lval = three_r[P][lgp_pkg::LO_VAL_BIT];
      endcase
    end
    assign dir = decode3(mode);
    always_comb
    begin
      rem = lval;
      if (mode == lgp_pkg::MODE_REM_HOLD)
        rem = held_r[k];
      else if (mode == lgp_pkg::MODE_REM_DEF)
        rem = link_up[P] ? remote_val[k] : lval;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pin_out[k]  <= 1'b0;
        pin_oe[k]   <= 1'b0;
        pin_func[k] <= 1'b0;
      end
      else
      begin
        pin_oe[k]   <= (dir == lgp_pkg::LGP_OUT);
        pin_out[k]  <= (dir == lgp_pkg::LGP_OUT) ? rem : 1'b0;
        pin_func[k] <= (dir == lgp_pkg::LGP_FUNC);
      end
    end
  end

  for (genvar j = 0; j < 2; j++)
  begin : g_pin56
    lgp_pkg::lgp_dir_t dir;
    logic              val;
    assign dir = decode2(j == 0 ? five_six_r[1:0] : five_six_r[5:4]);
    assign val = (j == 0) ? five_six_r[lgp_pkg::LO_VAL_BIT]
                          : five_six_r[lgp_pkg::HI_VAL_BIT];
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        pin56_out[j]  <= 1'b0;
        pin56_oe[j]   <= 1'b0;
        pin56_func[j] <= 1'b0;
      end
      else
      begin
        pin56_oe[j]   <= (dir == lgp_pkg::LGP_OUT);
        pin56_out[j]  <= (dir == lgp_pkg::LGP_OUT) && val;
        pin56_func[j] <= (dir == lgp_pkg::LGP_FUNC);
      end
    end
  end

  property p_tri_no_drive;
    @(posedge pclk) disable iff (!presetn)
    (one_two_r[0][1:0] == lgp_pkg::MODE_TRI_LO) |=> !pin_oe[0];
  endproperty
  a_tri_no_drive: assert property (p_tri_no_drive)
    else $error("pin one drives in high impedance mode");

  property p_out_mode;
    @(posedge pclk) disable iff (!presetn)
    (one_two_r[0][2:0] == lgp_pkg::MODE_OUT) |=>
      pin_oe[0] && pin_out[0] == $past(one_two_r[0][3]);
  endproperty
  a_out_mode: assert property (p_out_mode)
    else $error("pin one local output wrong");

  property p_in_mode;
    @(posedge pclk) disable iff (!presetn)
    (one_two_r[0][6:4] == lgp_pkg::MODE_IN) |=> !pin_oe[1] && !pin_func[1];
  endproperty
  a_in_mode: assert property (p_in_mode)
    else $error("pin two input mode drives");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    (one_two_r[0][2:0] == lgp_pkg::MODE_REM_HOLD && !link_up[0]
      && $stable(one_two_r[0])) ##1 (!link_up[0] && $stable(one_two_r[0]))
      |=> $stable(pin_out[0]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("remote hold value changed on lost link");

  property p_default;
    @(posedge pclk) disable iff (!presetn)
    (three_r[0][2:0] == lgp_pkg::MODE_REM_DEF && !link_up[0]) |=>
      pin_out[2] == $past(three_r[0][3]);
  endproperty
  a_default: assert property (p_default)
    else $error("remote default did not fall back");

  property p_pin6;
    @(posedge pclk) disable iff (!presetn)
    pin56_out[1] |-> pin56_oe[1] && $past(five_six_r[7]);
  endproperty
  a_pin6: assert property (p_pin6)
    else $error("pin six driven outside output mode");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (three_r[0][7:4] == 4'h0) && (three_r[1][7:4] == 4'h0)
      && (five_six_r[6] == 1'b0) && (five_six_r[2] == 1'b0);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit set");

  property p_redirect;
    @(posedge pclk) disable iff (!presetn)
    (wr_acc && !unmapped && idx == lgp_pkg::IDX_PINS_ONE_TWO && port_sel_r)
      |=> $stable(one_two_r[0]) && one_two_r[1] == $past(pwdata[7:0]);
  endproperty
  a_redirect: assert property (p_redirect)
    else $error("port select redirect failed");

endmodule : lgp_pin_config
`default_nettype wire
